// file: pbs_pkg_mem.sv
// constants, types and the small synchronous memory of the power sequencer
`default_nettype none

package pbs_pkg;
   // ***************************
   // register map
   // ***************************
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_LOSS = 12'h004;
   localparam logic [11:0] ADDR_FILL = 12'h008;
   localparam logic [11:0] ADDR_FG = 12'h00C;
   localparam logic [11:0] ADDR_BG = 12'h010;
   localparam logic [11:0] ADDR_POS = 12'h014;
   localparam logic [11:0] ADDR_STAT = 12'h018;
   localparam logic [11:0] ADDR_APPLY = 12'h01C;
   localparam logic [3:0] PAGE_STEP = 4'h1;
   localparam logic [3:0] PAGE_TEXT = 4'h2;
   // ctrl and pos field positions
   localparam int CTRL_RUN_LSB = 0;
   localparam int CTRL_OVL_EN = 4;
   localparam int CTRL_VFLIP = 5;
   localparam int CTRL_HFLIP = 6;
   localparam int CTRL_SCALE_LSB = 8;
   localparam int CTRL_LOSS_LSB = 10;
   localparam int POS_V_LSB = 16;
   // reset values
   localparam logic [15:0] LOSS_RST = 16'h000A;
   localparam logic [23:0] FILL_RST = 24'h000000;
   localparam logic [23:0] FG_RST = 24'hFFFFFF;
   localparam logic [23:0] BG_RST = 24'h000080;
   // ***************************
   // sizes and timing
   // ***************************
   localparam int STEP_W = 21;
   localparam int TEXT_LINES = 3;
   localparam int TEXT_COLS = 20;
   localparam logic [5:0] TEXT_CHARS = 6'h3C;
   localparam logic [11:0] BOX_W = 12'h0A0;
   localparam logic [11:0] BOX_H = 12'h018;
   localparam logic [3:0] LAST_STEP = 4'hF;
   localparam int CLK_HZ = 20_000_000;
   localparam int STEP_UNIT_MS = 1;
   localparam int LOSS_UNIT_MS = 100;
   localparam int CYC_PER_MS = CLK_HZ / 1000 * STEP_UNIT_MS;
   localparam int CYC_PER_TENTH = CLK_HZ / 1000 * LOSS_UNIT_MS;

   typedef enum logic [4:0] {
      ACT_END, ACT_PNL_PWR, ACT_VIDEO, ACT_BL_PWR, ACT_BL_SW, ACT_DISC,
      ACT_DISC_EN, ACT_SUP, ACT_SUP_EN, ACT_DELAY
   } pbs_act_t;
   typedef enum logic [1:0] {LOSS_FILL, LOSS_PANEL, LOSS_BL, LOSS_BOTH} pbs_loss_t;
   typedef enum logic [1:0] {LIST_PNL_UP, LIST_PNL_DN, LIST_BL_UP, LIST_BL_DN} pbs_list_t;
   typedef struct packed {
      logic [15:0] param;
      pbs_act_t act;
   } pbs_step_t;
   typedef struct packed {
      logic [7:0] r;
      logic [7:0] g;
      logic [7:0] b;
   } pbs_rgb_t;
   typedef struct packed {
      logic de;
      logic [11:0] x;
      logic [11:0] y;
      pbs_rgb_t rgb;
   } pbs_pix_t;
endpackage : pbs_pkg

// ***************************
// memory with registered read
// ***************************
module pbs_mem #(parameter int W = 8, parameter int AW = 6) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [W-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [W-1:0] rdata
);
   logic [W-1:0] mem [2**AW];

   always_ff @(posedge pclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata <= '0;
      end else begin
         rdata <= mem[raddr];
      end
   end
endmodule // pbs_mem

`default_nettype wire

// file: pbs_top.sv
// panel and backlight power sequencer with video-loss fill and text overlay
`default_nettype none

module pbs_top import pbs_pkg::*; #(
   parameter int unsigned CYC_MS = CYC_PER_MS,
   parameter int unsigned CYC_TENTH = CYC_PER_TENTH
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic vid_valid_pin,
   input wire pbs_pix_t vid_in,
   output pbs_pix_t vid_out,
   output logic [7:0] font_code,
   output logic [2:0] font_row,
   input wire logic [7:0] font_bits,
   output logic panel_supply_switch,
   output logic video_gate_en,
   output logic bl_power,
   output logic bl_switch,
   output logic [7:0] disc_out,
   output logic [3:0] sup_out,
   output logic nv_wr,
   output logic [5:0] nv_addr,
   output logic [7:0] nv_data
);
   // ***************************
   // apb slave
   // ***************************
   logic wr_acc, rd_setup, page_step, page_text, mapped;
   logic [15:0] ctrl_r, loss_dly_r;
   logic [23:0] fill_r, fg_r, bg_r;
   logic [27:0] pos_r;
   logic [31:0] stat_w, rd_mux;
   logic [3:0] run_wr;
   logic apply_wr;

   assign page_step = (paddr[11:8] == PAGE_STEP);
   assign page_text = (paddr[11:8] == PAGE_TEXT) && (paddr[7:2] < TEXT_CHARS);
   assign mapped = page_step || page_text || (paddr[11:5] == 7'h00);
   assign wr_acc = psel && penable && pwrite && mapped;
   assign rd_setup = psel && !penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign run_wr = (wr_acc && paddr == ADDR_CTRL) ? pwdata[CTRL_RUN_LSB +: 4] : 4'h0;
   assign apply_wr = wr_acc && (paddr == ADDR_APPLY);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= '0;
         loss_dly_r <= LOSS_RST;
         fill_r <= FILL_RST;
         fg_r <= FG_RST;
         bg_r <= BG_RST;
         pos_r <= '0;
      end else if (wr_acc) begin
         unique case (paddr)
            ADDR_CTRL: ctrl_r <= {pwdata[15:4], 4'h0};
            ADDR_LOSS: loss_dly_r <= pwdata[15:0];
            ADDR_FILL: fill_r <= pwdata[23:0];
            ADDR_FG: fg_r <= pwdata[23:0];
            ADDR_BG: bg_r <= pwdata[23:0];
            ADDR_POS: pos_r <= pwdata[27:0];
            default: ;
         endcase
      end
   end

   // memory pages are write-only and read back as zero
   always_comb begin
      unique case (paddr)
         ADDR_CTRL: rd_mux = {16'h0000, ctrl_r};
         ADDR_LOSS: rd_mux = {16'h0000, loss_dly_r};
         ADDR_FILL: rd_mux = {8'h00, fill_r};
         ADDR_FG: rd_mux = {8'h00, fg_r};
         ADDR_BG: rd_mux = {8'h00, bg_r};
         ADDR_POS: rd_mux = {4'h0, pos_r};
         ADDR_STAT: rd_mux = stat_w;
         default: rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (rd_setup) begin
         prdata <= rd_mux;
      end
   end

   // ***************************
   // video valid and loss timer
   // ***************************
   logic vv_meta_r, vv_r, loss_done_r, loss_fire, fill_on_r;
   logic [31:0] tenth_pre_r;
   logic [15:0] tenth_cnt_r;
   pbs_loss_t loss_act;
   assign loss_act = pbs_loss_t'(ctrl_r[CTRL_LOSS_LSB +: 2]);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vv_meta_r <= 1'b0;
         vv_r <= 1'b0;
      end else begin
         vv_meta_r <= vid_valid_pin;
         vv_r <= vv_meta_r;
      end
   end

   assign loss_fire = !vv_r && !loss_done_r && (tenth_cnt_r >= loss_dly_r);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tenth_pre_r <= '0;
         tenth_cnt_r <= '0;
         loss_done_r <= 1'b1;
      end else if (vv_r) begin
         tenth_pre_r <= '0;
         tenth_cnt_r <= '0;
         loss_done_r <= 1'b0;
      end else if (loss_fire) begin
         loss_done_r <= 1'b1;
      end else if (!loss_done_r) begin
         if (tenth_pre_r == CYC_TENTH - 1) begin
            tenth_pre_r <= '0;
            tenth_cnt_r <= tenth_cnt_r + 16'h0001;
         end else begin
            tenth_pre_r <= tenth_pre_r + 1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fill_on_r <= 1'b0;
      end else if (vv_r) begin
         fill_on_r <= 1'b0;
      end else if (loss_fire && loss_act == LOSS_FILL) begin
         fill_on_r <= 1'b1;
      end
   end

   // ***************************
   // step sequencer
   // ***************************
   typedef enum logic [2:0] {S_IDLE, S_FETCH, S_EXEC, S_DELAY} pbs_state_t;
   pbs_state_t state_r;
   logic [3:0] pend_r, loss_req, pick;
   logic [1:0] list_r;
   logic [3:0] idx_r;
   logic [STEP_W-1:0] step_rd;
   pbs_step_t step;
   logic is_bl, legal, last;
   logic [15:0] ms_left_r;
   logic [31:0] ms_pre_r;

   assign step = pbs_step_t'(step_rd);
   assign is_bl = list_r[1];
   assign last = (idx_r == LAST_STEP);
   assign loss_req = (loss_fire && loss_act == LOSS_PANEL) ? 4'b0010 :
                     (loss_fire && loss_act == LOSS_BL) ? 4'b1000 :
                     (loss_fire && loss_act == LOSS_BOTH) ? 4'b1010 : 4'b0000;
   assign pick = (state_r != S_IDLE) ? 4'b0000 : (pend_r & (~pend_r + 4'h1));

   // each list kind accepts its own actions
   always_comb begin
      unique case (step.act)
         ACT_PNL_PWR, ACT_VIDEO, ACT_SUP, ACT_SUP_EN: legal = !is_bl;
         ACT_BL_PWR, ACT_BL_SW: legal = is_bl;
         ACT_DISC, ACT_DISC_EN, ACT_DELAY: legal = 1'b1;
         default: legal = 1'b0;
      endcase
   end

   pbs_mem #(.W(STEP_W), .AW(6)) u_step_mem (
      .pclk(pclk),
      .presetn(presetn),
      .we(wr_acc && page_step),
      .waddr(paddr[7:2]),
      .wdata(pwdata[STEP_W-1:0]),
      .raddr({list_r, idx_r}),
      .rdata(step_rd)
   );

   // new requests win over the pick that clears them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_r <= '0;
      end else begin
         pend_r <= (pend_r & ~pick) | run_wr | loss_req;
      end
   end

   // one step at a time, in order
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= S_IDLE;
         list_r <= '0;
         idx_r <= '0;
      end else begin
         unique case (state_r)
            S_IDLE: if (|pend_r) begin
               list_r <= pick[0] ? 2'd0 : pick[1] ? 2'd1 : pick[2] ? 2'd2 : 2'd3;
               idx_r <= '0;
               state_r <= S_FETCH;
            end
            S_FETCH: state_r <= S_EXEC;
            S_EXEC: begin
               if (step.act == ACT_END || (last && step.act != ACT_DELAY)) begin
                  state_r <= S_IDLE;
               end else if (step.act == ACT_DELAY && step.param != 16'h0000) begin
                  state_r <= S_DELAY;
               end else begin
                  idx_r <= idx_r + 4'h1;
                  state_r <= last ? S_IDLE : S_FETCH;
               end
            end
            S_DELAY: if (ms_left_r == 16'h0000) begin
               idx_r <= idx_r + 4'h1;
               state_r <= last ? S_IDLE : S_FETCH;
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ms_left_r <= '0;
         ms_pre_r <= '0;
      end else if (state_r == S_EXEC) begin
         ms_left_r <= step.param;
         ms_pre_r <= '0;
      end else if (state_r == S_DELAY && ms_left_r != 16'h0000) begin
         if (ms_pre_r == CYC_MS - 1) begin
            ms_pre_r <= '0;
            ms_left_r <= ms_left_r - 16'h0001;
         end else begin
            ms_pre_r <= ms_pre_r + 1;
         end
      end
   end

   // ***************************
   // step actions on outputs
   // ***************************
   logic exec_ok;
   logic [7:0] disc_r;
   logic [3:0] sup_r;
   logic disc_en_r, sup_en_r;
   assign exec_ok = (state_r == S_EXEC) && legal;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         panel_supply_switch <= 1'b0;
         video_gate_en <= 1'b0;
         bl_power <= 1'b0;
         bl_switch <= 1'b0;
      end else if (exec_ok) begin
         if (step.act == ACT_PNL_PWR) panel_supply_switch <= step.param[0];
         if (step.act == ACT_VIDEO) video_gate_en <= step.param[0];
         if (step.act == ACT_BL_PWR) bl_power <= step.param[0];
         if (step.act == ACT_BL_SW) bl_switch <= step.param[0];
      end
   end

   // discrete index in param[10:8], level in param[0]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         disc_r <= '0;
         disc_en_r <= 1'b0;
      end else if (exec_ok) begin
         if (step.act == ACT_DISC) disc_r[step.param[10:8]] <= step.param[0];
         if (step.act == ACT_DISC_EN) disc_en_r <= step.param[0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sup_r <= '0;
         sup_en_r <= 1'b0;
      end else if (exec_ok) begin
         if (step.act == ACT_SUP) sup_r[step.param[9:8]] <= step.param[0];
         if (step.act == ACT_SUP_EN) sup_en_r <= step.param[0];
      end
   end

   assign disc_out = disc_en_r ? disc_r : 8'h00;
   assign sup_out = sup_en_r ? sup_r : 4'h0;

   assign stat_w = {8'h00, disc_r, sup_r, sup_en_r, disc_en_r, fill_on_r, vv_r,
                    pend_r, list_r, (state_r != S_IDLE), nv_wr};

   // ***************************
   // overlay render pipeline
   // ***************************
   logic [1:0] scale;
   logic [11:0] hoff, voff, lx, ly, ux, uy, fx, fy;
   logic inbox, txt_busy_r;
   logic [5:0] txt_addr, save_idx_r;
   logic [7:0] txt_rd;
   pbs_pix_t s1_r;
   logic s1_box_r;
   logic [2:0] s1_px_r;
   pbs_rgb_t fill_c, fg_c, bg_c;

   assign scale = ctrl_r[CTRL_SCALE_LSB +: 2];
   assign hoff = pos_r[11:0];
   assign voff = pos_r[POS_V_LSB +: 12];
   assign fill_c = pbs_rgb_t'(fill_r);
   assign fg_c = pbs_rgb_t'(fg_r);
   assign bg_c = pbs_rgb_t'(bg_r);
   assign lx = vid_in.x - hoff;
   assign ly = vid_in.y - voff;

   function automatic logic [11:0] unscale(input logic [11:0] v, input logic [1:0] s);
      unique case (s)
         2'd0: unscale = v;
         2'd1: unscale = v >> 1;
         2'd2: unscale = v / 12'd3;
         default: unscale = v >> 2;
      endcase
   endfunction

   assign ux = unscale(lx, scale);
   assign uy = unscale(ly, scale);
   assign inbox = (vid_in.x >= hoff) && (vid_in.y >= voff) && (ux < BOX_W) && (uy < BOX_H);
   assign fx = ctrl_r[CTRL_HFLIP] ? (BOX_W - 12'h001 - ux) : ux;
   assign fy = ctrl_r[CTRL_VFLIP] ? (BOX_H - 12'h001 - uy) : uy;
   assign txt_addr = txt_busy_r ? save_idx_r : 6'(fy[4:3] * TEXT_COLS + fx[7:3]);

   pbs_mem #(.W(8), .AW(6)) u_text_mem (
      .pclk(pclk),
      .presetn(presetn),
      .we(wr_acc && page_text),
      .waddr(paddr[7:2]),
      .wdata(pwdata[7:0]),
      .raddr(txt_addr),
      .rdata(txt_rd)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r <= '0;
         s1_box_r <= 1'b0;
         s1_px_r <= '0;
         font_row <= '0;
      end else begin
         s1_r <= vid_in;
         s1_box_r <= inbox && ctrl_r[CTRL_OVL_EN];
         s1_px_r <= fx[2:0];
         font_row <= fy[2:0];
      end
   end
   assign font_code = txt_rd;

   // stall-free: save walk may corrupt a few overlay cells of one frame
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vid_out <= '0;
      end else if (!video_gate_en) begin
         vid_out <= '0;
      end else if (fill_on_r) begin
         vid_out.de <= s1_r.de;
         vid_out.x <= s1_r.x;
         vid_out.y <= s1_r.y;
         vid_out.rgb <= !s1_box_r ? fill_c : (font_bits[3'd7 - s1_px_r] ? fg_c : bg_c);
      end else begin
         vid_out <= s1_r;
      end
   end

   // ***************************
   // non-volatile text save
   // ***************************
   // apply copies text to storage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         txt_busy_r <= 1'b0;
         save_idx_r <= '0;
      end else if (apply_wr) begin
         txt_busy_r <= 1'b1;
         save_idx_r <= '0;
      end else if (txt_busy_r) begin
         txt_busy_r <= (save_idx_r != TEXT_CHARS - 6'd1);
         save_idx_r <= save_idx_r + 6'd1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nv_wr <= 1'b0;
         nv_addr <= '0;
      end else begin
         nv_wr <= txt_busy_r && !apply_wr;
         nv_addr <= save_idx_r;
      end
   end
   assign nv_data = txt_rd;

   // ***************************
   // checks
   // ***************************
   a_disc_gate: assert property (@(posedge pclk) disable iff (!presetn)
      !disc_en_r |-> disc_out == 8'h00) else $error("discretes drive while disabled");
   a_sup_gate: assert property (@(posedge pclk) disable iff (!presetn)
      !sup_en_r |-> sup_out == 4'h0) else $error("supply lines drive while disabled");
   a_step_single: assert property (@(posedge pclk) disable iff (!presetn)
      state_r == S_EXEC |=> state_r != S_EXEC) else $error("two steps executed back to back");
   a_delay_hold: assert property (@(posedge pclk) disable iff (!presetn)
      state_r == S_DELAY && ms_left_r != 16'h0000 |=> state_r == S_DELAY && $stable(idx_r))
      else $error("delay step left early");
   a_panel_pwr: assert property (@(posedge pclk) disable iff (!presetn)
      state_r == S_EXEC && !is_bl && step.act == ACT_PNL_PWR
      |=> panel_supply_switch == $past(step.param[0])) else $error("panel supply not set");
   a_bl_no_sup: assert property (@(posedge pclk) disable iff (!presetn)
      state_r == S_EXEC && is_bl |=> $stable(sup_r) && $stable(sup_en_r))
      else $error("backlight list touched supply lines");
   a_loss_wait: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(fill_on_r) |-> $past(tenth_cnt_r) >= $past(loss_dly_r) && !$past(vv_r))
      else $error("fill began before loss delay");
   a_fill_pixel: assert property (@(posedge pclk) disable iff (!presetn)
      video_gate_en && fill_on_r && !s1_box_r |=> vid_out.rgb == $past(fill_c))
      else $error("fill colour not driven");
   a_overlay_off: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl_r[CTRL_OVL_EN] |=> !s1_box_r) else $error("overlay drawn while disabled");
   a_nv_walk: assert property (@(posedge pclk) disable iff (!presetn)
      apply_wr ##1 !apply_wr |=> nv_wr && nv_addr == 6'd0) else $error("text save not started");
endmodule // pbs_top

`default_nettype wire

// file: pbs_far.sv
// far-side model: panel and backlight supplies plus glyph store
`default_nettype none

// ***************************
// panel, backlight and glyphs
// ***************************
module pbs_far (
   input wire logic panel_supply_switch,
   input wire logic bl_power,
   input wire logic [7:0] font_code,
   input wire logic [2:0] font_row,
   output logic [7:0] font_bits,
   output logic lit
);
   timeunit 1ns;
   timeprecision 1ps;
   // glyph rows differ per code and per row, so a wrong cell shows
   assign font_bits = font_code ^ {5'h00, font_row};
   // picture visible only with both supplies up
   assign lit = panel_supply_switch & bl_power;
endmodule // pbs_far

`default_nettype wire

// file: pbs_top_tb.sv
// self-checking bench of the power sequencer
`default_nettype none

module pbs_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pbs_pkg::*;
   // ***************************
   // signals
   // ***************************
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, vid_valid_pin = 1;
   logic pready, pslverr, panel_supply_switch, video_gate_en, bl_power, bl_switch, nv_wr, lit, err;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, q;
   pbs_pix_t vid_in = '0, vid_out;
   logic [7:0] font_code, font_bits, disc_out, nv_data;
   logic [2:0] font_row;
   logic [3:0] sup_out;
   logic [5:0] nv_addr;
   int bad_count = 0, n_checks = 0, cyc = 0, n;

   // short counts keep the run brief
   pbs_top #(.CYC_MS(4), .CYC_TENTH(8)) i_pbs_top (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pready, .prdata, .pslverr, .vid_valid_pin, .vid_in, .vid_out,
      .font_code, .font_row, .font_bits, .panel_supply_switch, .video_gate_en, .bl_power,
      .bl_switch, .disc_out, .sup_out, .nv_wr, .nv_addr, .nv_data);
   pbs_far i_pbs_far (.panel_supply_switch, .bl_power, .font_code, .font_row, .font_bits, .lit);

   always #25 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         finish_test;
      end
   end
   // ***************************
   // shared tasks
   // ***************************
   task chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", s, e, g);
      end
   endtask
   task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 0; penable <= 0;
   endtask
   task step(input int l, input int s, input logic [4:0] a, input logic [15:0] p);
      apb(12'(256 + l * 64 + s * 4), 1, {11'h000, p, a});
   endtask
   task wait_idle;
      do apb(ADDR_STAT, 0, 0); while (q[7:4] !== 4'h0 || q[1] !== 1'b0);
   endtask
   // ***************************
   // scenarios
   // ***************************
   task run_regs;
      apb(ADDR_LOSS, 0, 0);
      chk("loss", 32'h0000000A, q);
      apb(ADDR_FILL, 0, 0);
      chk("fill", 32'h00000000, q);
      apb(ADDR_FG, 0, 0);
      chk("fg", 32'h00FFFFFF, q);
      apb(ADDR_BG, 0, 0);
      chk("bg", 32'h00000080, q);
      apb(12'hFFC, 0, 0);
      chk("slverr", 32'h00000001, {31'h0, err});
   endtask
   task run_panel;
      step(0, 0, ACT_PNL_PWR, 16'h0001);
      step(0, 1, ACT_DELAY, 16'h0002);
      step(0, 2, ACT_DISC, 16'h0301);
      step(0, 3, ACT_DISC_EN, 16'h0001);
      step(0, 4, ACT_SUP, 16'h0101);
      step(0, 5, ACT_SUP_EN, 16'h0001);
      step(0, 6, ACT_VIDEO, 16'h0001);
      step(0, 7, ACT_BL_PWR, 16'h0001);
      step(0, 8, ACT_END, 16'h0000);
      apb(ADDR_CTRL, 1, 32'h00000001);
      do @(posedge pclk); while (panel_supply_switch !== 1'b1);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (disc_out === 8'h00);
      // two milliseconds of four cycles each at the least
      chk("delay held", 1, 32'(n >= 8));
      wait_idle;
      chk("disc", 8'h08, disc_out);
      chk("sup", 4'h2, sup_out);
      chk("video", 1, video_gate_en);
      chk("bl skip", 0, bl_power);
   endtask
   task run_bl;
      step(2, 0, ACT_BL_PWR, 16'h0001);
      step(2, 1, ACT_BL_SW, 16'h0001);
      step(2, 2, ACT_SUP, 16'h0001);
      step(2, 3, ACT_DISC, 16'h0001);
      step(2, 4, ACT_END, 16'h0000);
      apb(ADDR_CTRL, 1, 32'h00000004);
      wait_idle;
      chk("blpwr", 1, bl_power);
      chk("blsw", 1, bl_switch);
      chk("sup kept", 4'h2, sup_out);
      chk("disc2", 8'h09, disc_out);
      chk("lit", 1, lit);
   endtask
   task run_fill;
      apb(ADDR_FILL, 1, 32'h00123456);
      apb(ADDR_LOSS, 1, 1);
      apb(ADDR_CTRL, 1, 0);
      // cells read by the box checks: first cell, and last cell when mirrored
      apb(12'h200, 1, 32'h00000041);
      apb(12'h2EC, 1, 32'h00000057);
      vid_in <= {1'b1, 12'h001, 12'h001, 24'hABCDEF};
      repeat (4) @(posedge pclk);
      chk("pass", 32'h00ABCDEF, vid_out.rgb);
      chk("pass x", 32'h00000001, vid_out.x);
      vid_valid_pin <= 0;
      // one tenth is eight cycles here, so nothing may change yet
      repeat (6) @(posedge pclk);
      chk("early", 32'h00ABCDEF, vid_out.rgb);
      repeat (34) @(posedge pclk);
      chk("fill", 32'h00123456, vid_out.rgb);
      apb(ADDR_CTRL, 1, 32'h00000010);
      repeat (4) @(posedge pclk);
      // cell 0 row 1 column 1 is a lit glyph pixel
      chk("box fg", FG_RST, vid_out.rgb);
      apb(ADDR_CTRL, 1, 32'h00000070);
      repeat (4) @(posedge pclk);
      // mirrored onto cell 59 row 6 column 6, a dark glyph pixel
      chk("mirror", BG_RST, vid_out.rgb);
      apb(ADDR_CTRL, 1, 32'h00000310);
      repeat (4) @(posedge pclk);
      // four-times size puts this pixel on cell 0 row 0 column 0
      chk("scale", BG_RST, vid_out.rgb);
      apb(ADDR_POS, 1, 32'h00000002);
      apb(ADDR_CTRL, 1, 32'h00000010);
      repeat (4) @(posedge pclk);
      chk("offset", 32'h00123456, vid_out.rgb);
      vid_valid_pin <= 1;
      repeat (8) @(posedge pclk);
      chk("back", 32'h00ABCDEF, vid_out.rgb);
   endtask
   task run_loss;
      step(1, 0, ACT_PNL_PWR, 16'h0000);
      step(1, 1, ACT_VIDEO, 16'h0000);
      step(1, 2, ACT_END, 16'h0000);
      step(3, 0, ACT_BL_PWR, 16'h0000);
      step(3, 1, ACT_END, 16'h0000);
      // loss action: both power-down lists
      apb(ADDR_CTRL, 1, 32'h00000C00);
      vid_valid_pin <= 0;
      // sync, one tenth and the request land well inside twenty cycles
      repeat (20) @(posedge pclk);
      wait_idle;
      chk("no fill", 0, q[9]);
      chk("panel down", 0, panel_supply_switch);
      chk("bl down", 0, bl_power);
      chk("dark", 0, lit);
      chk("blank", 0, {vid_out.de, vid_out.rgb});
   endtask
   task run_nv;
      apb(12'h200, 1, 32'h00000041);
      apb(ADDR_APPLY, 1, 1);
      n = 0;
      repeat (80) begin
         @(posedge pclk);
         if (nv_wr === 1'b1) begin
            n++;
            if (nv_addr === 6'h00) q = {24'h000000, nv_data};
         end
      end
      chk("nv count", 60, n);
      chk("nv byte", 32'h00000041, q);
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1;
      run_regs;
      run_panel;
      run_bl;
      run_fill;
      run_nv;
      run_loss;
      finish_test;
   end
endmodule // pbs_top_tb

`default_nettype wire
